// ==== design/macp_checker.sv ====
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - system mode: romized flash readable and executable, never writable.
// - system mode: non-romized flash and application eeprom fully accessible.
// - system mode: user read-only, write-protected and write-once areas limit writes.
// - system mode: manufacturer protected area unwritable except one upper nibble.
// - system mode: application ram fully accessible.
// - user mode flash: segment level none, read, or read plus execute; no writes.
// - user mode eeprom and ram: segment level none, read-write, or read-write-execute.
// - user mode: no write or execute in manufacturer protected area; fuses limited.
// - firmware mode verify operations only when the verify grant register enables.
// - firmware mode ram access only inside the firewall window.
// - key coprocessor may read and write its own work ram.
// - option off: code from nvm cannot read rom or romized flash.
// - option off: no instruction fetch from ram.
// - copy engine reads of rom or nvm gated by two options.
// - full-duplex copy has no rom, flash, eeprom access outside user mode.
// - boot mode: all register groups except segment, test-only, banked core.
// - test mode: all register groups except segment and banked core.
// - firmware mode: read firewall, firmware and core registers, peripherals by firewall.
// - system mode: segment, management, firewall, peripheral and core registers.
// - user mode: core registers, peripherals by executing segment rights.
// - copy engine keeps register rights captured at its start.
// - read-only exceptions: status register, clock select, segment size test.
// - any refused register access raises an exception.
// - segmentation configuration clears to zero at reset, disabling user code.
module macp_checker (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [7:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic [7:0]                     reg_rdata,
	input  wire macp_pkg::macp_mode_type    cpu_mode,
	input  wire macp_pkg::macp_mem_req_type mem_req,
	output logic                           mem_grant,
	output logic                           mem_deny,
	input  wire macp_pkg::macp_sfr_req_type sfr_req,
	input  wire logic [15:0]               seg_periph_rights,
	output logic                           sfr_grant,
	output logic                           sfr_exception,
	input  wire logic                      copy_start,
	input  wire logic                      copy_done,
	input  wire logic                      opt_rom_read_nvm,
	input  wire logic                      opt_ram_exec,
	input  wire logic                      opt_copy_rom_read,
	input  wire logic                      opt_copy_nvm_read
);
	import macp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic in_window(
		input logic [15:0] addr,
		input logic [15:0] base,
		input logic [15:0] size
	);
		logic [16:0] top;
		top = {1'b0, base} + {1'b0, size};
		in_window = (addr >= base) && ({1'b0, addr} < top);
	endfunction

	function automatic logic seg_allows(
		input logic [1:0] lvl,
		input logic       rd,
		input logic       wr,
		input logic       ex,
		input logic       wr_ok
	);
		logic lvl_on;
		lvl_on = (lvl == LVL_DATA) || (lvl == LVL_EXEC);
		seg_allows = (rd && lvl_on) || (wr && wr_ok && lvl_on) || (ex && lvl == LVL_EXEC);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [7:0]     verify_r;
	logic [7:0]     base_lo_r;
	logic [7:0]     base_hi_r;
	logic [7:0]     size_lo_r;
	logic [7:0]     size_hi_r;
	logic [7:0]     fwr_lo_r;
	logic [7:0]     fwr_hi_r;
	logic [7:0]     segcfg_r;
	logic [7:0]     status_r;
	logic [7:0]     denycnt_r;
	logic [7:0]     reg_rdata_r;
	logic           mem_grant_r;
	logic           mem_deny_r;
	logic           sfr_grant_r;
	logic           sfr_exc_r;
	logic           copy_active_r;
	macp_mode_type  copy_mode_r;
	logic [15:0]    copy_seg_r;
	logic [15:0]    copy_fwr_r;

	wire wr_verify  = reg_wr && (reg_addr == OFS_VERIFY);
	wire wr_base_lo = reg_wr && (reg_addr == OFS_BASE_LO);
	wire wr_base_hi = reg_wr && (reg_addr == OFS_BASE_HI);
	wire wr_size_lo = reg_wr && (reg_addr == OFS_SIZE_LO);
	wire wr_size_hi = reg_wr && (reg_addr == OFS_SIZE_HI);
	wire wr_fwr_lo  = reg_wr && (reg_addr == OFS_FWR_LO);
	wire wr_fwr_hi  = reg_wr && (reg_addr == OFS_FWR_HI);
	wire wr_segcfg  = reg_wr && (reg_addr == OFS_SEGCFG);

	// unmapped offsets read as zero
	wire [7:0] rd_mux =
		(reg_addr == OFS_VERIFY)  ? verify_r  :
		(reg_addr == OFS_BASE_LO) ? base_lo_r :
		(reg_addr == OFS_BASE_HI) ? base_hi_r :
		(reg_addr == OFS_SIZE_LO) ? size_lo_r :
		(reg_addr == OFS_SIZE_HI) ? size_hi_r :
		(reg_addr == OFS_FWR_LO)  ? fwr_lo_r  :
		(reg_addr == OFS_FWR_HI)  ? fwr_hi_r  :
		(reg_addr == OFS_SEGCFG)  ? segcfg_r  :
		(reg_addr == OFS_STATUS)  ? status_r  :
		(reg_addr == OFS_DENYCNT) ? denycnt_r : 8'h00;
	wire [7:0] reg_rdata_nxt = reg_rd ? rd_mux : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// memory request decode
	wire op_rd  = mem_req.op == OP_READ;
	wire op_wr  = mem_req.op == OP_WRITE;
	wire op_ex  = mem_req.op == OP_EXEC;
	wire op_vz  = mem_req.op == OP_VZERO;
	wire op_vp  = mem_req.op == OP_VPROG;
	wire op_wo  = mem_req.op == OP_WONCE;
	wire op_wp  = mem_req.op == OP_WPROT;
	wire rg_rom  = mem_req.region == RG_ROM;
	wire rg_romz = mem_req.region == RG_FL_ROMZ;
	wire rg_nvfl = mem_req.region == RG_FL_NVM;
	wire rg_eapp = mem_req.region == RG_EE_APP;
	wire rg_uro  = mem_req.region == RG_EE_URO;
	wire rg_uwp  = mem_req.region == RG_EE_UWP;
	wire rg_uwo  = mem_req.region == RG_EE_UWO;
	wire rg_mwp  = mem_req.region == RG_EE_MWP;
	wire rg_fuse = mem_req.region == RG_EE_FUSE;
	wire rg_ram  = mem_req.region == RG_RAM;
	wire rg_mfr  = rg_uro || rg_uwp || rg_uwo || rg_mwp || rg_fuse;
	wire rg_ee   = rg_eapp || rg_mfr;
	wire rg_fl   = rg_romz || rg_nvfl;
	wire rg_cold = rg_rom || rg_romz;
	wire rg_nvm  = rg_ee || rg_nvfl;
	wire fetch_nvm = (mem_req.fetch_region == RG_FL_NVM) || (mem_req.fetch_region >= RG_EE_APP &&
		mem_req.fetch_region <= RG_EE_FUSE);

	wire fuse_ok = (op_rd && mem_req.fuse_rwx[RWX_R]) || (op_wr && mem_req.fuse_rwx[RWX_W]) ||
		(op_ex && mem_req.fuse_rwx[RWX_X]);
	wire rdex = op_rd || op_ex;

	wire sys_romz = rdex;
	wire sys_full = rdex || op_wr;
	// write-once never reaches the last three bytes of its area
	wire sys_uwo  = rdex || (op_wo && mem_req.addr < UWO_LIMIT);
	wire sys_mwp  = rdex || (op_wp && mem_req.addr == MWP_NIB_OFS && mem_req.wmask[3:0] == 4'h0);
	wire sys_ok =
		rg_romz ? sys_romz :
		(rg_nvfl || rg_eapp || rg_ram) ? sys_full :
		rg_uro  ? rdex :
		rg_uwp  ? (rdex || op_wp) :
		rg_uwo  ? sys_uwo :
		rg_mwp  ? sys_mwp :
		rg_fuse ? fuse_ok : 1'b0;

	// empty segment config disables every user segment
	wire seg_en   = segcfg_r[SEG_EN_BIT];
	wire user_fl  = seg_allows(mem_req.seg_level, op_rd, op_wr, op_ex, 1'b0);
	wire user_rw  = seg_allows(mem_req.seg_level, op_rd, op_wr, op_ex, 1'b1);
	// manufacturer area keeps its system limits on top of the segment grant
	// segment rights never allow fetch in the manufacturer protected area
	wire mwp_exec = rg_mwp && op_ex;
	wire user_ok  = seg_en && (rg_fl ? user_fl : (rg_eapp || rg_ram) ? user_rw :
		rg_mfr ? (user_rw && sys_ok && !mwp_exec) : 1'b0);

	wire [15:0] win_base = {base_hi_r, base_lo_r};
	wire [15:0] win_size = {size_hi_r, size_lo_r};
	wire fw_win = in_window(mem_req.addr, win_base, win_size);
	wire fw_ok =
		(rg_fl && op_vz && verify_r[VG_FL_ZERO]) ||
		(rg_fl && op_vp && verify_r[VG_FL_PROG]) ||
		(rg_eapp && op_vz && verify_r[VG_EE_ZERO]) ||
		(rg_ram && (op_rd || op_wr) && fw_win);

	wire mode_ok =
		(cpu_mode == MODE_TEST) ? 1'b1 :
		(cpu_mode == MODE_SYS)  ? sys_ok :
		(cpu_mode == MODE_USER) ? user_ok :
		(cpu_mode == MODE_FW)   ? fw_ok : 1'b0;

	wire is_cpu  = mem_req.initiator == INI_CPU;
	wire is_copy = mem_req.initiator == INI_COPY;
	wire is_fd   = mem_req.initiator == INI_FDCOPY;
	wire is_pkc  = mem_req.initiator == INI_PKC;

	wire cfg_deny =
		(is_cpu && op_rd && rg_cold && fetch_nvm && !opt_rom_read_nvm) ||
		(op_ex && rg_ram && !opt_ram_exec) ||
		(is_copy && op_rd && rg_cold && !opt_copy_rom_read) ||
		(is_copy && op_rd && rg_nvm && !opt_copy_nvm_read);
	wire fd_deny  = is_fd && cpu_mode != MODE_USER && (rg_cold || rg_nvm);
	wire pkc_ok   = rg_ram && (op_rd || op_wr) && in_window(mem_req.addr, PKRAM_BASE, PKRAM_SIZE);

	wire mem_ok = is_pkc ? pkc_ok : (mode_ok && !cfg_deny && !fd_deny);

	////////////////////////////////////////////////////////////////////////
	// register group check, copy engine uses rights captured at its start
	wire            use_copy = sfr_req.copy && copy_active_r;
	macp_mode_type  eff_mode;
	assign eff_mode = use_copy ? copy_mode_r : cpu_mode;
	wire [15:0] eff_seg = use_copy ? copy_seg_r : seg_periph_rights;
	wire [15:0] eff_fwr = use_copy ? copy_fwr_r : {fwr_hi_r, fwr_lo_r};
	wire seg_bit  = eff_seg[sfr_req.periph];
	wire fwr_bit  = eff_fwr[sfr_req.periph];
	wire g_seg    = sfr_req.group == GRP_SEGCFG;
	wire g_sys    = sfr_req.group == GRP_SYSMGMT;
	wire g_fwc    = sfr_req.group == GRP_FWCFG;
	wire g_fwos   = sfr_req.group == GRP_FWOS;
	wire g_tonly  = sfr_req.group == GRP_TESTONL;
	wire g_per    = sfr_req.group == GRP_PERIPH;
	wire g_core   = sfr_req.group == GRP_CORE;
	wire g_bank   = sfr_req.group == GRP_COREBNK;
	wire s_rd     = !sfr_req.write;
	wire csr_rd   = s_rd && sfr_req.special == SPC_CSR;

	wire boot_sfr = !(g_seg || g_tonly || g_bank);
	wire test_sfr = !(g_seg || g_bank);
	wire fw_sfr   = (g_fwc && s_rd) || g_fwos || g_core || (g_per && fwr_bit) ||
		csr_rd || (s_rd && sfr_req.special == SPC_CLKSEL) || (s_rd && sfr_req.special == SPC_ESIZE);
	wire sys_sfr  = g_seg || g_sys || g_fwc || g_per || g_core || g_bank;
	wire user_sfr = g_core || g_bank || (g_per && seg_bit) || csr_rd;

	wire sfr_ok =
		(eff_mode == MODE_BOOT) ? boot_sfr :
		(eff_mode == MODE_TEST) ? test_sfr :
		(eff_mode == MODE_FW)   ? fw_sfr :
		(eff_mode == MODE_SYS)  ? sys_sfr :
		(eff_mode == MODE_USER) ? user_sfr : 1'b0;

	////////////////////////////////////////////////////////////////////////
	// decisions leave as registered strobes; targets act only on a grant
	wire mem_grant_nxt = mem_req.valid && mem_ok;
	wire mem_deny_nxt  = mem_req.valid && !mem_ok;
	wire sfr_grant_nxt = sfr_req.valid && sfr_ok;
	wire sfr_exc_nxt   = sfr_req.valid && !sfr_ok;
	wire any_deny      = mem_deny_nxt || sfr_exc_nxt;
	wire [7:0] status_nxt = mem_deny_nxt ? {mem_req.region, 1'b0, mem_req.op} :
		sfr_exc_nxt ? {4'h0, 1'b1, 3'h0} : status_r;
	// counter saturates so software never sees a wrap to zero
	wire [7:0] denycnt_nxt = (any_deny && denycnt_r != 8'hFF) ? denycnt_r + 8'h01 : denycnt_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			verify_r    <= RST_REG;
			base_lo_r   <= RST_REG;
			base_hi_r   <= RST_REG;
			size_lo_r   <= RST_REG;
			size_hi_r   <= RST_REG;
			fwr_lo_r    <= RST_REG;
			fwr_hi_r    <= RST_REG;
			segcfg_r    <= RST_REG;
			status_r    <= RST_REG;
			denycnt_r   <= RST_REG;
			reg_rdata_r <= 8'h00;
			mem_grant_r <= 1'b0;
			mem_deny_r  <= 1'b0;
			sfr_grant_r <= 1'b0;
			sfr_exc_r   <= 1'b0;
		end else begin
			if (wr_verify)  verify_r  <= reg_wdata;
			if (wr_base_lo) base_lo_r <= reg_wdata;
			if (wr_base_hi) base_hi_r <= reg_wdata;
			if (wr_size_lo) size_lo_r <= reg_wdata;
			if (wr_size_hi) size_hi_r <= reg_wdata;
			if (wr_fwr_lo)  fwr_lo_r  <= reg_wdata;
			if (wr_fwr_hi)  fwr_hi_r  <= reg_wdata;
			if (wr_segcfg)  segcfg_r  <= reg_wdata;
			status_r    <= status_nxt;
			denycnt_r   <= denycnt_nxt;
			reg_rdata_r <= reg_rdata_nxt;
			mem_grant_r <= mem_grant_nxt;
			mem_deny_r  <= mem_deny_nxt;
			sfr_grant_r <= sfr_grant_nxt;
			sfr_exc_r   <= sfr_exc_nxt;
		end
	end

	// snapshot of rights taken when the copy engine starts
	always_ff @(posedge clk) begin
		if (rst) begin
			copy_active_r <= 1'b0;
			copy_mode_r   <= MODE_BOOT;
			copy_seg_r    <= 16'h0000;
			copy_fwr_r    <= 16'h0000;
		end else if (copy_start) begin
			copy_active_r <= 1'b1;
			copy_mode_r   <= cpu_mode;
			copy_seg_r    <= seg_periph_rights;
			copy_fwr_r    <= {fwr_hi_r, fwr_lo_r};
		end else if (copy_done) begin
			copy_active_r <= 1'b0;
		end
	end

	assign reg_rdata     = reg_rdata_r;
	assign mem_grant     = mem_grant_r;
	assign mem_deny      = mem_deny_r;
	assign sfr_grant     = sfr_grant_r;
	assign sfr_exception = sfr_exc_r;

	////////////////////////////////////////////////////////////////////////
	AST_SYS_ROMZ_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && is_cpu && cpu_mode == MODE_SYS && rg_romz && op_wr)
		|=> (mem_deny && !mem_grant))
		else $error("system write to romized flash not refused");

	AST_SYS_RAM_READ: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && is_cpu && cpu_mode == MODE_SYS && rg_ram && op_rd)
		|=> mem_grant)
		else $error("system read of ram not granted");

	AST_USER_FLASH_NO_WRITE: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && cpu_mode == MODE_USER && rg_fl && op_wr)
		|=> mem_deny)
		else $error("user write to flash granted");

	AST_USER_MWP: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && !is_pkc && cpu_mode == MODE_USER && rg_mwp && (op_wr || op_ex))
		|=> !mem_grant)
		else $error("user write or execute in protected area granted");

	AST_FW_WINDOW: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && is_cpu && cpu_mode == MODE_FW && rg_ram && !fw_win)
		|=> mem_deny)
		else $error("firmware access outside ram window granted");

	AST_RAM_EXEC: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && !opt_ram_exec && rg_ram && op_ex)
		|=> (mem_deny && !mem_grant))
		else $error("ram fetch granted with option off");

	AST_FD_NVM: assert property (@(posedge clk) disable iff (rst)
		(mem_req.valid && is_fd && cpu_mode == MODE_SYS && rg_nvm)
		|=> mem_deny)
		else $error("full-duplex copy reached nvm outside user mode");

	AST_BOOT_SEGCFG: assert property (@(posedge clk) disable iff (rst)
		(sfr_req.valid && !use_copy && cpu_mode == MODE_BOOT && g_seg)
		|=> (sfr_exception && !sfr_grant))
		else $error("boot access to segment configuration allowed");

	AST_EXC_ON_DENY: assert property (@(posedge clk) disable iff (rst)
		(sfr_req.valid && !sfr_ok)
		|=> (sfr_exception && $past(sfr_req.valid)))
		else $error("refused register access raised no exception");

	AST_COPY_HOLDS: assert property (@(posedge clk) disable iff (rst)
		(copy_active_r && !copy_start)
		|=> ($stable(copy_mode_r) && $stable(copy_seg_r)))
		else $error("copy engine rights changed while running");

	AST_SEG_RESET: assert property (@(posedge clk) disable iff (rst)
		$fell(rst)
		|-> (segcfg_r == 8'h00 && !seg_en))
		else $error("segment configuration not cleared by reset");

	AST_ONE_ANSWER: assert property (@(posedge clk) disable iff (rst)
		!(mem_grant && mem_deny)
		&& !(sfr_grant && sfr_exception))
		else $error("grant and deny given together");

endmodule

// ==== design/macp_pkg.sv ====
package macp_pkg;

	typedef enum logic [2:0] {
		MODE_BOOT = 3'h0,
		MODE_TEST = 3'h1,
		MODE_FW   = 3'h2,
		MODE_SYS  = 3'h3,
		MODE_USER = 3'h4
	} macp_mode_type;

	typedef enum logic [3:0] {
		RG_ROM     = 4'h0,
		RG_FL_ROMZ = 4'h1,
		RG_FL_NVM  = 4'h2,
		RG_EE_APP  = 4'h3,
		RG_EE_URO  = 4'h4,
		RG_EE_UWP  = 4'h5,
		RG_EE_UWO  = 4'h6,
		RG_EE_MWP  = 4'h7,
		RG_EE_FUSE = 4'h8,
		RG_RAM     = 4'h9,
		RG_OTHER   = 4'hA
	} macp_region_type;

	typedef enum logic [2:0] {
		OP_READ  = 3'h0,
		OP_WRITE = 3'h1,
		OP_EXEC  = 3'h2,
		OP_VZERO = 3'h3,
		OP_VPROG = 3'h4,
		OP_WONCE = 3'h5,
		OP_WPROT = 3'h6
	} macp_op_type;

	typedef enum logic [1:0] {
		INI_CPU    = 2'h0,
		INI_COPY   = 2'h1,
		INI_FDCOPY = 2'h2,
		INI_PKC    = 2'h3
	} macp_init_type;

	typedef enum logic [3:0] {
		GRP_SEGCFG  = 4'h0,
		GRP_SYSMGMT = 4'h1,
		GRP_FWCFG   = 4'h2,
		GRP_FWOS    = 4'h3,
		GRP_TEST    = 4'h4,
		GRP_TESTONL = 4'h5,
		GRP_PERIPH  = 4'h6,
		GRP_CORE    = 4'h7,
		GRP_COREBNK = 4'h8
	} macp_group_type;

	typedef enum logic [1:0] {
		SPC_NONE   = 2'h0,
		SPC_CSR    = 2'h1,
		SPC_CLKSEL = 2'h2,
		SPC_ESIZE  = 2'h3
	} macp_special_type;

	typedef struct packed {
		logic            valid;
		macp_init_type   initiator;
		macp_op_type     op;
		macp_region_type region;
		logic [15:0]     addr;
		logic [7:0]      wmask;
		macp_region_type fetch_region;
		logic [1:0]      seg_level;
		logic [2:0]      fuse_rwx;
	} macp_mem_req_type;

	typedef struct packed {
		logic             valid;
		logic             write;
		logic             copy;
		macp_group_type   group;
		macp_special_type special;
		logic [3:0]       periph;
	} macp_sfr_req_type;

	localparam logic [7:0] OFS_VERIFY   = 8'h00;
	localparam logic [7:0] OFS_BASE_LO  = 8'h01;
	localparam logic [7:0] OFS_BASE_HI  = 8'h02;
	localparam logic [7:0] OFS_SIZE_LO  = 8'h03;
	localparam logic [7:0] OFS_SIZE_HI  = 8'h04;
	localparam logic [7:0] OFS_FWR_LO   = 8'h05;
	localparam logic [7:0] OFS_FWR_HI   = 8'h06;
	localparam logic [7:0] OFS_SEGCFG   = 8'h07;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_DENYCNT  = 8'h09;
	localparam logic [7:0] RST_REG      = 8'h00;
	localparam int         VG_FL_ZERO   = 0;
	localparam int         VG_FL_PROG   = 1;
	localparam int         VG_EE_ZERO   = 2;
	localparam int         SEG_EN_BIT   = 0;
	localparam logic [1:0] LVL_NONE     = 2'h0;
	localparam logic [1:0] LVL_DATA     = 2'h1;
	localparam logic [1:0] LVL_EXEC     = 2'h2;
	localparam int         RWX_R        = 2;
	localparam int         RWX_W        = 1;
	localparam int         RWX_X        = 0;
	localparam logic [15:0] UWO_SIZE    = 16'h0040;
	localparam logic [15:0] UWO_LIMIT   = UWO_SIZE - 16'h0003;
	localparam logic [15:0] MWP_NIB_OFS = 16'h0000;
	localparam logic [15:0] PKRAM_BASE  = 16'h0800;
	localparam logic [15:0] PKRAM_SIZE  = 16'h0400;

endpackage

// ==== sim/macp_req_model.sv ====
`timescale 1ns/10ps
module macp_req_model (
	input  wire logic                   clk,
	output macp_pkg::macp_mem_req_type  mem_req,
	output macp_pkg::macp_sfr_req_type  sfr_req,
	input  wire logic                   mem_grant,
	input  wire logic                   mem_deny,
	input  wire logic                   sfr_grant,
	input  wire logic                   sfr_exception
);
	import macp_pkg::*;

	initial begin
		mem_req = '0;
		sfr_req = '0;
	end

	////////////////////////////////////////////////////////////////
	// one request per call; between requests the fields carry junk
	// so that a design looking at them without valid is caught
	task automatic send_mem(input macp_mem_req_type r, output logic g, output logic d);
		@(posedge clk);
		mem_req <= r;
		@(posedge clk);
		mem_req <= macp_mem_req_type'({1'b0, ~r[$bits(r)-2:0]});
		#1;
		g = mem_grant;
		d = mem_deny;
	endtask

	task automatic send_sfr(input macp_sfr_req_type r, output logic g, output logic x);
		@(posedge clk);
		sfr_req <= r;
		@(posedge clk);
		sfr_req <= macp_sfr_req_type'({1'b0, ~r[$bits(r)-2:0]});
		#1;
		g = sfr_grant;
		x = sfr_exception;
	endtask
endmodule

// ==== sim/macp_checker_tb.sv ====
`timescale 1ns/10ps
module macp_checker_tb;
	import macp_pkg::*;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [7:0]        reg_addr = 8'h00;
	logic [7:0]        reg_wdata = 8'h00;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [7:0]        reg_rdata;
	macp_mode_type     cpu_mode = MODE_BOOT;
	macp_mem_req_type  mem_req;
	macp_sfr_req_type  sfr_req;
	logic [15:0]       seg_periph_rights = 16'h0000;
	logic              mem_grant, mem_deny, sfr_grant, sfr_exception;
	logic              copy_start = 1'b0;
	logic              copy_done = 1'b0;
	logic [3:0]        opt = 4'hF;
	logic [7:0]        wm = 8'hFF;
	macp_region_type   fr = RG_OTHER;
	logic [2:0]        fz = 3'h0;
	int                miscompares = 0;
	int                tests_run = 0;

	macp_checker macp_checker_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_mode(cpu_mode), .mem_req(mem_req),
		.mem_grant(mem_grant), .mem_deny(mem_deny), .sfr_req(sfr_req), .seg_periph_rights(seg_periph_rights),
		.sfr_grant(sfr_grant), .sfr_exception(sfr_exception), .copy_start(copy_start), .copy_done(copy_done),
		.opt_rom_read_nvm(opt[3]), .opt_ram_exec(opt[2]), .opt_copy_rom_read(opt[1]), .opt_copy_nvm_read(opt[0]));
	macp_req_model macp_req_model_i (.clk(clk), .mem_req(mem_req), .sfr_req(sfr_req), .mem_grant(mem_grant),
		.mem_deny(mem_deny), .sfr_grant(sfr_grant), .sfr_exception(sfr_exception));

	initial begin
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		tests_run++;
		if (v !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, v);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask

	// grant and deny both compared: exactly one may answer
	task automatic m(input macp_mode_type md, input macp_init_type it, input macp_op_type op,
		input macp_region_type rg, input logic [15:0] a, input logic [1:0] l, input logic e);
		logic g;
		logic d;
		cpu_mode <= md;
		macp_req_model_i.send_mem('{1'b1, it, op, rg, a, wm, fr, l, fz}, g, d);
		chk("mem_grant", {7'h00, e}, {7'h00, g});
		chk("mem_deny", {7'h00, !e}, {7'h00, d});
	endtask

	task automatic s(input macp_mode_type md, input logic w, input logic cp, input macp_group_type gp,
		input macp_special_type sp, input logic [3:0] p, input logic e);
		logic g;
		logic x;
		cpu_mode <= md;
		macp_req_model_i.send_sfr('{1'b1, w, cp, gp, sp, p}, g, x);
		chk("sfr_grant", {7'h00, e}, {7'h00, g});
		chk("sfr_exception", {7'h00, !e}, {7'h00, x});
	endtask

	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_SEGCFG, 8'h00);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_RAM, 16'h0000, LVL_EXEC, 1'b0);
		wr(OFS_SEGCFG, 8'h01);
		wr(8'h0F, 8'hA5);
		rd(8'h0F, 8'h00);
		m(MODE_SYS, INI_CPU, OP_READ, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_EXEC, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_FL_NVM, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_EE_APP, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_EE_URO, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_EE_UWP, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_CPU, OP_WPROT, RG_EE_UWP, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WONCE, RG_EE_UWO, 16'h003C, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WONCE, RG_EE_UWO, 16'h003D, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_CPU, OP_WRITE, RG_EE_MWP, 16'h0000, LVL_NONE, 1'b0);
		wm = 8'hF0;
		m(MODE_SYS, INI_CPU, OP_WPROT, RG_EE_MWP, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_WPROT, RG_EE_MWP, 16'h0001, LVL_NONE, 1'b0);
		wm = 8'h0F;
		m(MODE_SYS, INI_CPU, OP_WPROT, RG_EE_MWP, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_CPU, OP_EXEC, RG_RAM, 16'h0FFF, LVL_NONE, 1'b1);
		m(MODE_USER, INI_CPU, OP_READ, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_USER, INI_CPU, OP_READ, RG_FL_NVM, 16'h0000, LVL_DATA, 1'b1);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_FL_NVM, 16'h0000, LVL_DATA, 1'b0);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_FL_ROMZ, 16'h0000, LVL_EXEC, 1'b1);
		m(MODE_USER, INI_CPU, OP_WRITE, RG_FL_NVM, 16'h0000, LVL_EXEC, 1'b0);
		m(MODE_USER, INI_CPU, OP_WRITE, RG_RAM, 16'h0000, LVL_DATA, 1'b1);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_EE_APP, 16'h0000, LVL_DATA, 1'b0);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_RAM, 16'h0000, LVL_EXEC, 1'b1);
		m(MODE_USER, INI_CPU, OP_WRITE, RG_EE_MWP, 16'h0000, LVL_EXEC, 1'b0);
		m(MODE_USER, INI_CPU, OP_EXEC, RG_EE_MWP, 16'h0000, LVL_EXEC, 1'b0);
		fz = 3'h4;
		m(MODE_USER, INI_CPU, OP_READ, RG_EE_FUSE, 16'h0000, LVL_EXEC, 1'b1);
		m(MODE_USER, INI_CPU, OP_WRITE, RG_EE_FUSE, 16'h0000, LVL_EXEC, 1'b0);
		m(MODE_FW, INI_CPU, OP_VZERO, RG_FL_NVM, 16'h0000, LVL_NONE, 1'b0);
		wr(OFS_VERIFY, 8'h07);
		m(MODE_FW, INI_CPU, OP_VZERO, RG_FL_NVM, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_FW, INI_CPU, OP_VPROG, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_FW, INI_CPU, OP_VZERO, RG_EE_APP, 16'h0000, LVL_NONE, 1'b1);
		wr(OFS_VERIFY, 8'h05);
		m(MODE_FW, INI_CPU, OP_VPROG, RG_FL_NVM, 16'h0000, LVL_NONE, 1'b0);
		wr(OFS_BASE_LO, 8'h00);
		wr(OFS_BASE_HI, 8'h01);
		wr(OFS_SIZE_LO, 8'h10);
		wr(OFS_SIZE_HI, 8'h00);
		rd(OFS_BASE_HI, 8'h01);
		m(MODE_FW, INI_CPU, OP_WRITE, RG_RAM, 16'h0100, LVL_NONE, 1'b1);
		m(MODE_FW, INI_CPU, OP_READ, RG_RAM, 16'h010F, LVL_NONE, 1'b1);
		m(MODE_FW, INI_CPU, OP_READ, RG_RAM, 16'h0110, LVL_NONE, 1'b0);
		m(MODE_FW, INI_CPU, OP_WRITE, RG_RAM, 16'h00FF, LVL_NONE, 1'b0);
		m(MODE_FW, INI_CPU, OP_READ, RG_RAM, 16'h0800, LVL_NONE, 1'b0);
		m(MODE_FW, INI_PKC, OP_WRITE, RG_RAM, 16'h0800, LVL_NONE, 1'b1);
		m(MODE_FW, INI_PKC, OP_READ, RG_RAM, 16'h0BFF, LVL_NONE, 1'b1);
		opt = 4'h0;
		fr = RG_FL_NVM;
		m(MODE_SYS, INI_CPU, OP_READ, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b0);
		fr = RG_RAM;
		m(MODE_SYS, INI_CPU, OP_READ, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_SYS, INI_CPU, OP_EXEC, RG_RAM, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_COPY, OP_READ, RG_FL_ROMZ, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_COPY, OP_READ, RG_EE_APP, 16'h0000, LVL_NONE, 1'b0);
		opt = 4'hF;
		m(MODE_SYS, INI_COPY, OP_READ, RG_EE_APP, 16'h0000, LVL_NONE, 1'b1);
		m(MODE_TEST, INI_FDCOPY, OP_READ, RG_FL_NVM, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_SYS, INI_FDCOPY, OP_READ, RG_EE_APP, 16'h0000, LVL_NONE, 1'b0);
		m(MODE_TEST, INI_FDCOPY, OP_READ, RG_RAM, 16'h0000, LVL_NONE, 1'b1);
		s(MODE_BOOT, 1'b0, 1'b0, GRP_SEGCFG, SPC_NONE, 4'h0, 1'b0);
		s(MODE_BOOT, 1'b1, 1'b0, GRP_TESTONL, SPC_NONE, 4'h0, 1'b0);
		s(MODE_BOOT, 1'b0, 1'b0, GRP_COREBNK, SPC_NONE, 4'h0, 1'b0);
		s(MODE_BOOT, 1'b1, 1'b0, GRP_SYSMGMT, SPC_NONE, 4'h0, 1'b1);
		s(MODE_TEST, 1'b1, 1'b0, GRP_TESTONL, SPC_NONE, 4'h0, 1'b1);
		s(MODE_TEST, 1'b1, 1'b0, GRP_SEGCFG, SPC_NONE, 4'h0, 1'b0);
		s(MODE_TEST, 1'b0, 1'b0, GRP_COREBNK, SPC_NONE, 4'h0, 1'b0);
		wr(OFS_FWR_LO, 8'h08);
		s(MODE_FW, 1'b0, 1'b0, GRP_FWCFG, SPC_NONE, 4'h0, 1'b1);
		s(MODE_FW, 1'b1, 1'b0, GRP_FWCFG, SPC_NONE, 4'h0, 1'b0);
		s(MODE_FW, 1'b1, 1'b0, GRP_FWOS, SPC_NONE, 4'h0, 1'b1);
		s(MODE_FW, 1'b1, 1'b0, GRP_COREBNK, SPC_NONE, 4'h0, 1'b0);
		s(MODE_FW, 1'b1, 1'b0, GRP_PERIPH, SPC_NONE, 4'h3, 1'b1);
		s(MODE_FW, 1'b1, 1'b0, GRP_PERIPH, SPC_NONE, 4'h2, 1'b0);
		s(MODE_FW, 1'b0, 1'b0, GRP_PERIPH, SPC_CLKSEL, 4'h2, 1'b1);
		s(MODE_FW, 1'b0, 1'b0, GRP_SYSMGMT, SPC_CSR, 4'h0, 1'b1);
		s(MODE_FW, 1'b1, 1'b0, GRP_SYSMGMT, SPC_CSR, 4'h0, 1'b0);
		s(MODE_FW, 1'b0, 1'b0, GRP_TEST, SPC_ESIZE, 4'h0, 1'b1);
		s(MODE_USER, 1'b0, 1'b0, GRP_SYSMGMT, SPC_CSR, 4'h0, 1'b1);
		s(MODE_SYS, 1'b1, 1'b0, GRP_SEGCFG, SPC_NONE, 4'h0, 1'b1);
		s(MODE_SYS, 1'b1, 1'b0, GRP_FWCFG, SPC_NONE, 4'h0, 1'b1);
		s(MODE_SYS, 1'b1, 1'b0, GRP_COREBNK, SPC_NONE, 4'h0, 1'b1);
		s(MODE_USER, 1'b1, 1'b0, GRP_CORE, SPC_NONE, 4'h0, 1'b1);
		s(MODE_USER, 1'b1, 1'b0, GRP_SEGCFG, SPC_NONE, 4'h0, 1'b0);
		seg_periph_rights <= 16'h0001;
		s(MODE_USER, 1'b1, 1'b0, GRP_PERIPH, SPC_NONE, 4'h0, 1'b1);
		s(MODE_USER, 1'b1, 1'b0, GRP_PERIPH, SPC_NONE, 4'h1, 1'b0);
		// snapshot in user mode, live state in system mode
		@(posedge clk);
		copy_start <= 1'b1;
		@(posedge clk);
		copy_start <= 1'b0;
		seg_periph_rights <= 16'h0000;
		s(MODE_SYS, 1'b1, 1'b1, GRP_PERIPH, SPC_NONE, 4'h0, 1'b1);
		s(MODE_SYS, 1'b1, 1'b1, GRP_PERIPH, SPC_NONE, 4'h1, 1'b0);
		copy_done <= 1'b1;
		@(posedge clk);
		copy_done <= 1'b0;
		s(MODE_SYS, 1'b1, 1'b1, GRP_PERIPH, SPC_NONE, 4'h1, 1'b1);
		rd(OFS_STATUS, 8'h08);
		give_verdict();
	end
endmodule
